/* verilog/cmc_map.svh */
// Register offsets, field positions, reset values and mux codes for the comparator control block.
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
`define CMC_ADDR_CTRL0_C1 4'h0
`define CMC_ADDR_CTRL1_C1 4'h1
`define CMC_ADDR_CTRL0_C2 4'h2
`define CMC_ADDR_CTRL1_C2 4'h3
`define CMC_ADDR_MIRROR 4'h4
`define CMC_ADDR_IRQ_FLAG 4'h5
`define CMC_ADDR_IRQ_EN 4'h6
`define CMC_ADDR_SHDN_EN 4'h7
`define CMC_CTRL0_RESET 8'h04
`define CMC_CTRL0_WMASK 8'h97
`define CMC_CTRL1_RESET 8'h00
`define CMC_BIT_ON 7
`define CMC_BIT_OUT 6
`define CMC_BIT_POL 4
`define CMC_BIT_SP 2
`define CMC_BIT_HYS 1
`define CMC_BIT_SYNC 0
`define CMC_BIT_INTP 7
`define CMC_BIT_INTN 6
`define CMC_SEL_AGND 3'h7
`define CMC_SEL_REF2 3'h6
`define CMC_SEL_DAC 3'h5
`define CMC_SEL_PIN0 3'h0
`define CMC_SEL_PIN3 3'h3
`endif

/* verilog/cmc_pkg.sv */
// Types shared by the comparator control block.
`default_nettype none
package cmc_pkg;
  typedef enum logic [2:0] {
    CMC_SRC_NONE = 3'b001,
    CMC_SRC_PIN = 3'b010,
    CMC_SRC_INT = 3'b100
  } cmc_src_t;
  typedef struct packed {
    logic [1:0] pos_route;
    logic [4:0] neg_route;
  } cmc_route_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cmc_bus_t;
endpackage
`default_nettype wire

/* verilog/cmc_top.sv */
// Control and status logic around two analog comparators.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_map.svh"

// Function
// - Positive select: 111 ground, 110 reference, 101 DAC, 000 pin zero, else open.
// - Negative select: 111 ground, 110 reference, 101/100 open, 011-000 pins three to zero.
// - Enable low disconnects every comparator input.
// - Control zero bit 7 enables comparator, resets to 0.
// - Output bit 6 shows comparison, inverted when polarity bit 4 set.
// - Speed bit 2 resets to 1; software never writes 0.
// - Bit 1 turns hysteresis on, resets to 0.
// - Sync mode updates timer and pin output on timer clock falling edge.
// - Without sync mode timer and pin output pass unlatched (here registered from nxt_out in ext_ff each system cycle).
// - Rising enable bit 7 sets flag on every output rise.
// - Falling enable bit 6 sets flag on every output fall.
// - Mirror register bit 0 comparator one, bit 1 comparator two, rest zero.
// - Control zero bits 5 and 3 read 0, ignore writes.
// - Active output with shutdown enable suspends waveform generator at once (here shdn_ff raises the request one core clock later).
// - In sleep with timer on system clock, synced output stops updating.
// - Enabled comparator interrupt wakes the device from sleep.
// - Flag stays until software clears; new edge during clear wins.
// - Polarity or enable toggles while disabled can still set the flag.
// - Internal output latched every system cycle; external unlatched unless synced (here ext_ff registers nxt_out every system cycle).
module cmc_top
  import cmc_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Analog comparator core
  input wire logic [1:0] i_cmp_raw,
  input wire logic i_timer_clk,
  input wire logic i_sleep,
  input wire logic i_timer_clk_sys,
  output logic [1:0] o_enable,
  output logic [1:0] o_hysteresis,
  output logic [1:0] o_speed,
  output cmc_route_t [1:0] o_route,
  // Timer, pin and waveform generator
  output logic [1:0] o_cmp_ext,
  output logic o_shutdown_req,
  output logic [1:0] o_irq_flag,
  output logic o_wake
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] ctrl0_ff [1:0];
  logic [7:0] ctrl1_ff [1:0];
  logic [1:0] irq_flag_ff;
  logic [1:0] irq_en_ff;
  logic [1:0] shdn_en_ff;
  logic [1:0] raw_s1_ff;
  logic [1:0] raw_s2_ff;
  logic [1:0] raw_s3_ff;
  logic [1:0] raw_stable_ff;
  logic [1:0] out_ff;
  logic [1:0] out_prev_ff;
  logic [1:0] sync_out_ff;
  logic [2:0] tclk_sync_ff;
  logic [1:0] ext_ff;
  logic [1:0] en_ff;
  logic [1:0] hys_ff;
  logic [1:0] sp_ff;
  cmc_route_t [1:0] route_ff;
  logic shdn_ff;
  logic wake_ff;
  logic [7:0] rdata_ff;
  logic [1:0] nxt_out;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] flag_clr;
  logic tclk_fall;
  cmc_bus_t bus;

  assign bus = '{rd: i_rd, wr: i_wr, addr: i_addr, wdata: i_wdata};

  // Pin input synchroniser; the stable level updates once stages two and three agree.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      raw_s1_ff <= 2'h0;
      raw_s2_ff <= 2'h0;
      raw_s3_ff <= 2'h0;
      raw_stable_ff <= 2'h0;
      tclk_sync_ff <= 3'h0;
    end
    else
    begin
      raw_s1_ff <= i_cmp_raw;
      raw_s2_ff <= raw_s1_ff;
      raw_s3_ff <= raw_s2_ff;
      raw_stable_ff <= (raw_s2_ff & raw_s3_ff) | (raw_stable_ff & (raw_s2_ff | raw_s3_ff));
      tclk_sync_ff <= {tclk_sync_ff[1:0], i_timer_clk};
    end
  end

  // Falling edge of the timer clock seen through the synchroniser.
  assign tclk_fall = tclk_sync_ff[2] & ~tclk_sync_ff[1];

  // ----------------------------------------
  // Per-comparator logic
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cmp
      logic [3:0] a0;
      logic [3:0] a1;
      assign a0 = (g == 0) ? `CMC_ADDR_CTRL0_C1 : `CMC_ADDR_CTRL0_C2;
      assign a1 = (g == 0) ? `CMC_ADDR_CTRL1_C1 : `CMC_ADDR_CTRL1_C2;

      assign nxt_out[g] = (ctrl0_ff[g][`CMC_BIT_ON] & raw_stable_ff[g]) ^ ctrl0_ff[g][`CMC_BIT_POL];

      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          ctrl0_ff[g] <= `CMC_CTRL0_RESET;
          ctrl1_ff[g] <= `CMC_CTRL1_RESET;
        end
        else
        begin
          if (bus.wr && (bus.addr == a0))
          begin
            ctrl0_ff[g] <= bus.wdata & `CMC_CTRL0_WMASK;
          end
          else if (bus.wr && (bus.addr == a1))
          begin
            ctrl1_ff[g] <= bus.wdata;
          end
        end
      end

      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          out_ff[g] <= 1'b0;
          out_prev_ff[g] <= 1'b0;
        end
        else
        begin
          out_ff[g] <= nxt_out[g];
          out_prev_ff[g] <= out_ff[g];
        end
      end

      assign rise[g] = out_ff[g] & ~out_prev_ff[g];
      assign fall[g] = ~out_ff[g] & out_prev_ff[g];
      assign flag_clr[g] = bus.wr && (bus.addr == `CMC_ADDR_IRQ_FLAG) && !bus.wdata[g];

      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          irq_flag_ff[g] <= 1'b0;
        end
        else if ((rise[g] && ctrl1_ff[g][`CMC_BIT_INTP]) || (fall[g] && ctrl1_ff[g][`CMC_BIT_INTN]))
        begin
          irq_flag_ff[g] <= 1'b1;
        end
        else if (flag_clr[g])
        begin
          irq_flag_ff[g] <= 1'b0;
        end
      end

      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          sync_out_ff[g] <= 1'b0;
        end
        else if (tclk_fall && !(i_sleep && i_timer_clk_sys))
        begin
          sync_out_ff[g] <= out_ff[g];
        end
      end

      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          ext_ff[g] <= 1'b0;
        end
        else
        begin
          ext_ff[g] <= ctrl0_ff[g][`CMC_BIT_SYNC] ? sync_out_ff[g] : nxt_out[g];
        end
      end

      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          route_ff[g] <= '0;
          en_ff[g] <= 1'b0;
          hys_ff[g] <= 1'b0;
          sp_ff[g] <= 1'b1;
        end
        else
        begin
          en_ff[g] <= ctrl0_ff[g][`CMC_BIT_ON];
          hys_ff[g] <= ctrl0_ff[g][`CMC_BIT_HYS];
          sp_ff[g] <= ctrl0_ff[g][`CMC_BIT_SP];
          route_ff[g] <= '0;
          if (ctrl0_ff[g][`CMC_BIT_ON])
          begin
            case (ctrl1_ff[g][5:3])
              `CMC_SEL_AGND: route_ff[g].pos_route <= 2'h3;
              `CMC_SEL_REF2: route_ff[g].pos_route <= 2'h2;
              `CMC_SEL_DAC: route_ff[g].pos_route <= 2'h1;
              default: route_ff[g].pos_route <= 2'h0;
            endcase
            route_ff[g].neg_route[4] <= (ctrl1_ff[g][5:3] == `CMC_SEL_PIN0);
            case (ctrl1_ff[g][2:0])
              `CMC_SEL_AGND: route_ff[g].neg_route[3:0] <= 4'h5;
              `CMC_SEL_REF2: route_ff[g].neg_route[3:0] <= 4'h6;
              3'h5, 3'h4: route_ff[g].neg_route[3:0] <= 4'h0;
              default: route_ff[g].neg_route[3:0] <= {1'b1, ctrl1_ff[g][2:0]};
            endcase
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Shared enables, shutdown and wake
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_en_ff <= 2'h0;
      shdn_en_ff <= 2'h0;
    end
    else if (bus.wr && (bus.addr == `CMC_ADDR_IRQ_EN))
    begin
      irq_en_ff <= bus.wdata[1:0];
    end
    else if (bus.wr && (bus.addr == `CMC_ADDR_SHDN_EN))
    begin
      shdn_en_ff <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      shdn_ff <= 1'b0;
      wake_ff <= 1'b0;
    end
    else
    begin
      shdn_ff <= |(nxt_out & shdn_en_ff);
      wake_ff <= i_sleep && |(irq_flag_ff & irq_en_ff);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // mirror layout
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_ff <= 8'h00;
    end
    else if (!bus.rd)
    begin
      rdata_ff <= 8'h00;
    end
    else if (bus.addr == `CMC_ADDR_CTRL0_C1)
    begin
      rdata_ff <= ctrl0_ff[0] | {1'b0, out_ff[0], 6'h00};
    end
    else if (bus.addr == `CMC_ADDR_CTRL1_C1)
    begin
      rdata_ff <= ctrl1_ff[0];
    end
    else if (bus.addr == `CMC_ADDR_CTRL0_C2)
    begin
      rdata_ff <= ctrl0_ff[1] | {1'b0, out_ff[1], 6'h00};
    end
    else if (bus.addr == `CMC_ADDR_CTRL1_C2)
    begin
      rdata_ff <= ctrl1_ff[1];
    end
    else if (bus.addr == `CMC_ADDR_MIRROR)
    begin
      rdata_ff <= {6'h00, out_ff};
    end
    else if (bus.addr == `CMC_ADDR_IRQ_FLAG)
    begin
      rdata_ff <= {6'h00, irq_flag_ff};
    end
    else if (bus.addr == `CMC_ADDR_IRQ_EN)
    begin
      rdata_ff <= {6'h00, irq_en_ff};
    end
    else if (bus.addr == `CMC_ADDR_SHDN_EN)
    begin
      rdata_ff <= {6'h00, shdn_en_ff};
    end
    else
    begin
      rdata_ff <= 8'h00;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_enable = en_ff;
  assign o_hysteresis = hys_ff;
  assign o_speed = sp_ff;
  assign o_route = route_ff;
  assign o_cmp_ext = ext_ff;
  assign o_shutdown_req = shdn_ff;
  assign o_irq_flag = irq_flag_ff;
  assign o_wake = wake_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_RISE_FLAG: assert property (rise[0] && ctrl1_ff[0][7] |=> irq_flag_ff[0])
    else $error("rising edge did not set flag");
  AST_FALL_FLAG: assert property (fall[1] && ctrl1_ff[1][6] |=> irq_flag_ff[1])
    else $error("falling edge did not set flag");
  AST_SET_WINS: assert property (rise[0] && ctrl1_ff[0][7] && flag_clr[0] |=> irq_flag_ff[0])
    else $error("clear beat a new edge");
  AST_MIRROR: assert property (bus.rd && bus.addr == `CMC_ADDR_MIRROR |=> o_rdata == {6'h00, $past(out_ff)})
    else $error("mirror read wrong");
  AST_UNIMPL: assert property (ctrl0_ff[0][5] == 1'b0 && ctrl0_ff[0][3] == 1'b0)
    else $error("unimplemented bit set");
  AST_DISC: assert property (!ctrl0_ff[1][7] |=> o_route[1] == '0)
    else $error("inputs connected while disabled");
  AST_ASYNC: assert property (!ctrl0_ff[0][0] |=> o_cmp_ext[0] == $past(nxt_out[0]))
    else $error("async path latched");
  AST_SYNC_HOLD: assert property (ctrl0_ff[0][0] && !$past(tclk_fall) |-> $stable(sync_out_ff[0]))
    else $error("sync output moved without timer edge");
  AST_SHDN: assert property (|(nxt_out & shdn_en_ff) |=> o_shutdown_req)
    else $error("shutdown not requested");
  AST_POL: assert property (!ctrl0_ff[0][7] |=> out_ff[0] == $past(ctrl0_ff[0][4]))
    else $error("disabled output ignores polarity");

  COV_RISE: cover property (rise[0] && ctrl1_ff[0][7]);
  COV_CLEAR: cover property (flag_clr[1] && irq_flag_ff[1]);
  COV_SYNC: cover property (ctrl0_ff[0][0] && tclk_fall);
  COV_WAKE: cover property (o_wake);

endmodule
`default_nettype wire

/* testbench/cmc_analog_model.sv */
// Behavioural model of the analog comparator cores and the timer clock source.
`timescale 1ns/1ns
`default_nettype none
module cmc_analog_model
(
  // Clock
  input wire logic i_core_clk,
  // Scenario controls
  input wire logic [1:0] i_vp_above,
  input wire logic i_run_timer,
  input wire logic i_sleep,
  input wire logic i_timer_clk_sys,
  // Block side
  input wire logic [1:0] i_enable,
  output logic [1:0] o_cmp_raw,
  output logic o_timer_clk
);
  logic [1:0] div_ff;
  assign o_cmp_raw = i_enable & i_vp_above;
  initial
  begin
    div_ff = 2'h0;
    o_timer_clk = 1'b0;
  end
  always @(posedge i_core_clk)
  begin
    if (i_run_timer && !(i_sleep && i_timer_clk_sys))
    begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3)
        o_timer_clk <= ~o_timer_clk;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_cmc_top.sv */
// Self-checking testbench for the comparator control block.
`timescale 1ns/1ns
`default_nettype none
module tb_cmc_top;
  import cmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] vp = 2'h0;
  logic run = 1'b0;
  logic sleep = 1'b0;
  logic sys = 1'b0;
  logic [7:0] rdata;
  logic [1:0] raw, en, hys, spd, ext, flag;
  logic tclk, shdn, wake;
  cmc_route_t [1:0] route;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  cmc_top cmc_top_inst (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_cmp_raw(raw), .i_timer_clk(tclk), .i_sleep(sleep), .i_timer_clk_sys(sys),
    .o_enable(en), .o_hysteresis(hys), .o_speed(spd), .o_route(route), .o_cmp_ext(ext),
    .o_shutdown_req(shdn), .o_irq_flag(flag), .o_wake(wake));
  cmc_analog_model cmc_analog_model_inst (.i_core_clk(clk), .i_vp_above(vp), .i_run_timer(run), .i_sleep(sleep),
    .i_timer_clk_sys(sys), .i_enable(en), .o_cmp_raw(raw), .o_timer_clk(tclk));

  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic test_reset();
    logic [7:0] d;
    rd_reg(4'h0, d);
    chk(d, 8'h04);
    rd_reg(4'h1, d);
    chk(d, 8'h00);
    rd_reg(4'h4, d);
    chk(d, 8'h00);
    chk({6'h0, spd}, 8'h03);
  endtask

  task automatic test_fields();
    logic [7:0] d;
    wr_reg(4'h2, 8'hff);
    wr_reg(4'h8, 8'h5a);
    wait_c(10);
    rd_reg(4'h2, d);
    chk(d, 8'hd7);
    chk({6'h0, hys}, 8'h02);
    chk({6'h0, en}, 8'h02);
    rd_reg(4'h4, d);
    chk(d, 8'h02);
    rd_reg(4'h8, d);
    chk(d, 8'h00);
    wr_reg(4'h2, 8'h04);
  endtask

  task automatic test_route();
    logic [7:0] pe, ne;
    for (int c = 0; c < 8; c++)
    begin
      pe = (c == 7) ? 8'h03 : (c == 6) ? 8'h02 : (c == 5) ? 8'h01 : 8'h00;
      ne = (c == 7) ? 8'h05 : (c == 6) ? 8'h06 : (c < 4) ? 8'h08 + 8'(c) : 8'h00;
      ne[4] = (c == 0);
      wr_reg(4'h0, 8'h84);
      wr_reg(4'h1, {2'h0, 3'(c), 3'(c)});
      wait_c(3);
      chk({6'h0, route[0].pos_route}, pe);
      chk({3'h0, route[0].neg_route}, ne);
      wr_reg(4'h0, 8'h04);
      wait_c(3);
      chk({1'b0, route[0]}, 8'h00);
    end
  endtask

  task automatic test_edges();
    logic [7:0] d;
    wr_reg(4'h0, 8'h84);
    wr_reg(4'h1, 8'hc0);
    wr_reg(4'h6, 8'h01);
    wait_c(10);
    wr_reg(4'h5, 8'h00);
    vp <= 2'h1;
    wait_c(10);
    rd_reg(4'h0, d);
    chk(d, 8'hc4);
    chk({7'h0, flag[0]}, 8'h01);
    sleep <= 1'b1;
    wait_c(3);
    chk({7'h0, wake}, 8'h01);
    sleep <= 1'b0;
    wr_reg(4'h5, 8'h00);
    wait_c(2);
    chk({7'h0, flag[0]}, 8'h00);
    wr_reg(4'h7, 8'h01);
    wait_c(3);
    chk({7'h0, shdn}, 8'h01);
    vp <= 2'h0;
    wait_c(10);
    chk({7'h0, flag[0]}, 8'h01);
    chk({7'h0, shdn}, 8'h00);
    wr_reg(4'h0, 8'h04);
    wr_reg(4'h5, 8'h00);
    wait_c(10);
    wr_reg(4'h0, 8'h14);
    wr_reg(4'h5, 8'h00);
    wait_c(2);
    chk({7'h0, flag[0]}, 8'h01);
    wait_c(8);
    rd_reg(4'h0, d);
    chk(d, 8'h54);
    chk({7'h0, flag[0]}, 8'h01);
  endtask

  task automatic test_sync();
    wr_reg(4'h0, 8'h85);
    wait_c(10);
    vp <= 2'h1;
    wait_c(12);
    chk({7'h0, ext[0]}, 8'h00);
    run <= 1'b1;
    wait_c(24);
    chk({7'h0, ext[0]}, 8'h01);
    sleep <= 1'b1;
    sys <= 1'b1;
    wait_c(4);
    vp <= 2'h0;
    wait_c(24);
    chk({7'h0, ext[0]}, 8'h01);
    sleep <= 1'b0;
    wait_c(24);
    chk({7'h0, ext[0]}, 8'h00);
    run <= 1'b0;
    wr_reg(4'h0, 8'h84);
    vp <= 2'h1;
    wait_c(10);
    chk({7'h0, ext[0]}, 8'h01);
  endtask

  initial
  begin
    wait_c(5);
    rst <= 1'b0;
    test_reset();
    test_fields();
    test_route();
    test_edges();
    test_sync();
    stop_test();
  end
endmodule
`default_nettype wire
